// ### logic/cpp_defs.vh
// constants for the clock phase and pipeline timing block
`ifndef CPP_DEFS_VH
`define CPP_DEFS_VH
`define CPP_PHASES 4
`define CPP_PC_W 13
`define CPP_INSN_W 14
`define CPP_DATA_W 8
`define CPP_DADDR_W 7
`define CPP_RESET_ADDR 13'h0000
`define CPP_NOP_WORD 14'h0000
`define CPP_PROG_DEPTH 2048
`define CPP_PROG_AW 11
`define CPP_OSC_EXTERNAL_RC_MODE 3'h0
`define CPP_OSC_INTERNAL_RC_MODE 3'h1
`define CPP_OSC_HS 3'h2
`define CPP_OSC_XT 3'h3
`define CPP_OSC_LP 3'h4
`define CPP_P2_GPIO 2'h0
`define CPP_P2_TMRCK 2'h1
`define CPP_P2_IRQ 2'h2
`define CPP_JMP_OP 3'h5
`define CPP_OP_HI 13
`define CPP_OP_LO 11
`endif

// ### logic/cpp_phase_gen.v
// four-phase generator dividing the input clock by four
`timescale 1ns/100ps
`include "cpp_defs.vh"
module cpp_phase_gen (
  // clock and reset
  input wire mclk,
  input wire rst,
  // one-hot phases
  output wire phase_1,
  output wire phase_2,
  output wire phase_3,
  output wire phase_4
);
  reg [3:0] ring_ff;
  always @(posedge mclk) begin
    if (rst) begin
      ring_ff <= 4'h1; // [RULE15]
    end else begin
      ring_ff <= {ring_ff[2:0], ring_ff[3]}; // [RULE1]
    end
  end
  assign phase_1 = ring_ff[0];
  assign phase_2 = ring_ff[1];
  assign phase_3 = ring_ff[2];
  assign phase_4 = ring_ff[3];
endmodule

// ### logic/cpp_prog_mem.v
// program memory with registered read data
`timescale 1ns/100ps
`include "cpp_defs.vh"
module cpp_prog_mem (
  // clock
  input wire mclk,
  // load port
  input wire wr_en,
  input wire [`CPP_PROG_AW-1:0] wr_addr,
  input wire [`CPP_INSN_W-1:0] wr_data,
  // fetch port
  input wire [`CPP_PROG_AW-1:0] rd_addr,
  output reg [`CPP_INSN_W-1:0] rd_data
);
  reg [`CPP_INSN_W-1:0] mem [0:`CPP_PROG_DEPTH-1];
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### logic/cpp_core.v
// phase sequencer, two-stage fetch/execute pipeline and pin function muxing
//
// Contract
// [RULE1] input clock divided by four into four non-overlapping repeating phases
// [RULE2] program counter increments once per instruction cycle in phase_1
// [RULE3] fetched program word captured into the instruction latch at phase_4
// [RULE4] execute: word presented in phase_1, decoded and executed phase_2 to phase_4
// [RULE5] one instruction cycle is four phases; fetch overlaps execute
// [RULE6] program-counter-changing instructions take two cycles, discarding fetched word
// [RULE7] operand read from data memory in phase_2, result written in phase_4
// [RULE8] rc modes: port_bit4 may output cycle clock at quarter input rate
// [RULE9] port_bit4 is crystal drive only in crystal modes, else general I/O
// [RULE10] port_bit5 is general I/O only in internal rc mode, else clock input
// [RULE11] port_bit3 as master clear: low holds reset; otherwise input only
// [RULE12] port_bit3 pull-up forced on when used as master clear
// [RULE13] port_bit0, 1, 3 have software pull-up and change interrupt
// [RULE14] port_bit2 selects general I/O, timer clock input or external irq
// [RULE15] after reset start at phase_1 of fetch from reset address
`timescale 1ns/100ps
`include "cpp_defs.vh"
module cpp_core (
  // clock and reset
  input wire mclk,
  input wire rst,
  // configuration straps
  input wire [2:0] osc_mode,
  input wire master_clear_n_en,
  input wire cycle_clock_out_en,
  input wire [1:0] port_bit2_sel,
  // program memory load
  input wire pm_wr_en,
  input wire [`CPP_PROG_AW-1:0] pm_wr_addr,
  input wire [`CPP_INSN_W-1:0] pm_wr_data,
  // data memory side
  output reg [`CPP_DADDR_W-1:0] dmem_addr_ff,
  output wire dmem_rd,
  input wire [`CPP_DATA_W-1:0] dmem_rdata,
  output wire dmem_wr,
  output reg [`CPP_DATA_W-1:0] dmem_wdata_ff,
  // pipeline status
  output wire phase_1,
  output wire phase_2,
  output wire phase_3,
  output wire phase_4,
  output reg [`CPP_PC_W-1:0] program_counter_ff,
  output reg [`CPP_INSN_W-1:0] instruction_latch_ff,
  output reg flush_ff,
  output wire core_reset,
  // port pins, output enable low drives
  input wire [5:0] port_in,
  input wire [5:0] port_out,
  input wire [5:0] port_oe_n,
  output wire [5:0] pin_out,
  output wire [5:0] pin_oe_n,
  // software pull-up and change interrupt
  input wire [2:0] pullup_sw_en,
  input wire [2:0] ioc_en,
  output wire [2:0] pullup_on,
  output reg ioc_flag_ff,
  input wire ioc_clr,
  // pin function outputs
  output wire osc_drive_active,
  output wire osc_input_active,
  output wire timer_ext_clock_in,
  output wire ext_irq_in
);
  wire [`CPP_INSN_W-1:0] pm_rdata;
  reg [`CPP_INSN_W-1:0] fetch_ff;
  reg [`CPP_PC_W-1:0] fetch_addr_ff;
  reg [`CPP_DATA_W-1:0] operand_ff;
  reg [2:0] ioc_prev_ff;
  reg [`CPP_PC_W-1:0] nxt_pc;
  wire master_clear_n;
  wire crystal_mode;
  wire rc_mode;
  wire is_jump;
  wire cycle_clock_out;
  wire [2:0] ioc_bits;

  function is_jump_word;
    input [`CPP_INSN_W-1:0] w;
    begin
      is_jump_word = (w[`CPP_OP_HI:`CPP_OP_LO] == `CPP_JMP_OP);
    end
  endfunction

  cpp_phase_gen u_phase (
    .mclk(mclk),
    .rst(core_reset),
    .phase_1(phase_1),
    .phase_2(phase_2),
    .phase_3(phase_3),
    .phase_4(phase_4)
  );

  // address held from phase_1, so registered data stand well before phase_4
  cpp_prog_mem u_pmem (
    .mclk(mclk),
    .wr_en(pm_wr_en),
    .wr_addr(pm_wr_addr),
    .wr_data(pm_wr_data),
    .rd_addr(fetch_addr_ff[`CPP_PROG_AW-1:0]),
    .rd_data(pm_rdata)
  );

  assign master_clear_n = port_in[3];
  assign core_reset = rst | (master_clear_n_en & ~master_clear_n); // [RULE11]
  assign crystal_mode = (osc_mode == `CPP_OSC_HS) | (osc_mode == `CPP_OSC_XT) |
    (osc_mode == `CPP_OSC_LP);
  assign rc_mode = (osc_mode == `CPP_OSC_EXTERNAL_RC_MODE) | (osc_mode == `CPP_OSC_INTERNAL_RC_MODE);
  assign is_jump = ~flush_ff & is_jump_word(instruction_latch_ff);

  // jump target from low bits; counter runs one word ahead of the fetch
  always @* begin
    nxt_pc = program_counter_ff + 13'h0001;
    if (is_jump) begin
      nxt_pc = {2'h0, instruction_latch_ff[10:0]};
    end
  end

  always @(posedge mclk) begin
    if (core_reset) begin
      program_counter_ff <= `CPP_RESET_ADDR; // [RULE15]
      fetch_addr_ff <= `CPP_RESET_ADDR; // [RULE15]
      fetch_ff <= `CPP_NOP_WORD;
      instruction_latch_ff <= `CPP_NOP_WORD;
      flush_ff <= 1'b1;
      operand_ff <= 8'h00;
      dmem_wdata_ff <= 8'h00;
      dmem_addr_ff <= 7'h00;
    end else begin
      if (phase_4) begin
        fetch_ff <= pm_rdata; // [RULE3]
        if (is_jump) begin
          program_counter_ff <= nxt_pc; // [RULE6]
        end
      end
      if (phase_1) begin
        // fetch uses the count before the step, so reset fetches the reset word
        instruction_latch_ff <= fetch_ff; // [RULE4]
        flush_ff <= is_jump; // [RULE6]
        fetch_addr_ff <= program_counter_ff; // [RULE3] [RULE15]
        program_counter_ff <= program_counter_ff + 13'h0001; // [RULE2] [RULE5]
        dmem_addr_ff <= fetch_ff[6:0];
      end
      if (phase_2 & ~flush_ff) begin
        operand_ff <= dmem_rdata; // [RULE7]
      end
      if (phase_3 & ~flush_ff) begin
        dmem_wdata_ff <= operand_ff + 8'h01;
      end
    end
  end

  // flushed slot makes no data access, the discarded word is a bubble
  assign dmem_rd = phase_2 & ~flush_ff; // [RULE7]
  assign dmem_wr = phase_4 & ~flush_ff & ~is_jump; // [RULE7]

  // cycle clock high in phase_3 and phase_4, one pulse per cycle
  assign cycle_clock_out = phase_3 | phase_4; // [RULE8]

  assign osc_drive_active = crystal_mode; // [RULE9]
  assign osc_input_active = (osc_mode != `CPP_OSC_INTERNAL_RC_MODE); // [RULE10]

  assign pin_out[0] = port_out[0];
  assign pin_out[1] = port_out[1];
  assign pin_out[2] = port_out[2];
  assign pin_out[3] = 1'b0;
  assign pin_out[4] = (rc_mode & cycle_clock_out_en) ? cycle_clock_out : port_out[4]; // [RULE8]
  assign pin_out[5] = port_out[5];
  assign pin_oe_n[0] = port_oe_n[0];
  assign pin_oe_n[1] = port_oe_n[1];
  // timer clock and irq inputs keep the pin released
  assign pin_oe_n[2] = (port_bit2_sel == `CPP_P2_GPIO) ? port_oe_n[2] : 1'b1; // [RULE14]
  assign pin_oe_n[3] = 1'b1; // [RULE11]
  assign pin_oe_n[4] = crystal_mode ? 1'b1 :
    ((rc_mode & cycle_clock_out_en) ? 1'b0 : port_oe_n[4]); // [RULE9]
  assign pin_oe_n[5] = osc_input_active ? 1'b1 : port_oe_n[5]; // [RULE10]

  assign timer_ext_clock_in = (port_bit2_sel == `CPP_P2_TMRCK) & port_in[2]; // [RULE14]
  assign ext_irq_in = (port_bit2_sel == `CPP_P2_IRQ) & port_in[2]; // [RULE14]

  assign pullup_on[0] = pullup_sw_en[0]; // [RULE13]
  assign pullup_on[1] = pullup_sw_en[1]; // [RULE13]
  assign pullup_on[2] = pullup_sw_en[2] | master_clear_n_en; // [RULE12]

  assign ioc_bits = {port_in[3], port_in[1], port_in[0]};

  // set wins over clear so no change is lost
  always @(posedge mclk) begin
    if (rst) begin
      // follows the pins in reset so idle-high pins raise no false change
      ioc_prev_ff <= ioc_bits;
      ioc_flag_ff <= 1'b0;
    end else begin
      ioc_prev_ff <= ioc_bits;
      if (|((ioc_bits ^ ioc_prev_ff) & ioc_en)) begin
        ioc_flag_ff <= 1'b1; // [RULE13]
      end else if (ioc_clr) begin
        ioc_flag_ff <= 1'b0;
      end
    end
  end
endmodule

// ### sim/cpp_dmem_model.sv
// data register file model answering operand reads and destination writes
`timescale 1ns/100ps
`include "cpp_defs.vh"
module cpp_dmem_model (
  // clock
  input wire mclk,
  // data memory side of the core
  input wire [`CPP_DADDR_W-1:0] dmem_addr_ff,
  input wire dmem_rd,
  input wire dmem_wr,
  input wire [`CPP_DATA_W-1:0] dmem_wdata_ff,
  output wire [`CPP_DATA_W-1:0] dmem_rdata
);
  logic [`CPP_DATA_W-1:0] mem_ff [0:127];
  logic [`CPP_DATA_W-1:0] junk_ff = 8'h5a;
  initial for (int i = 0; i < 128; i++) mem_ff[i] = 8'(i * 3);
  // outside a read the bus toggles, so a late sample never sees old data
  assign dmem_rdata = dmem_rd ? mem_ff[dmem_addr_ff] : junk_ff;
  always @(posedge mclk) begin
    junk_ff <= ~junk_ff;
    if (dmem_wr) mem_ff[dmem_addr_ff] <= dmem_wdata_ff;
  end
endmodule

// ### sim/cpp_core_asserts.sv
// pipeline timing and pin function assertions for the core
`timescale 1ns/100ps
`include "cpp_defs.vh"
module cpp_core_asserts (
  // clock and resets
  input wire mclk,
  input wire rst,
  input wire core_reset,
  // straps and pins
  input wire [2:0] osc_mode,
  input wire master_clear_n_en,
  input wire [5:0] port_in,
  input wire osc_drive_active,
  input wire osc_input_active,
  // pipeline
  input wire phase_1,
  input wire phase_2,
  input wire phase_3,
  input wire phase_4,
  input wire [`CPP_PC_W-1:0] program_counter_ff,
  input wire [`CPP_INSN_W-1:0] instruction_latch_ff,
  input wire flush_ff,
  input wire dmem_rd,
  input wire dmem_wr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (core_reset);
  a_phase_order: assert property (phase_1 |=> phase_2 ##1 phase_3 ##1 phase_4 ##1 phase_1)
    else $error("phase order broken");
  a_pc_moves: assert property ($changed(program_counter_ff) && !$past(core_reset) |->
    $past(phase_1) || $past(phase_4)) else $error("pc moved off phase");
  a_latch_moves: assert property ($changed(instruction_latch_ff) && !$past(core_reset) |->
    $past(phase_1)) else $error("latch moved off phase_1");
  a_read_slot: assert property (dmem_rd |-> phase_2 && !flush_ff)
    else $error("operand read out of slot");
  a_write_slot: assert property (dmem_wr |-> phase_4 && !flush_ff)
    else $error("destination write out of slot");
  a_read_write: assert property (dmem_rd &&
    instruction_latch_ff[`CPP_OP_HI:`CPP_OP_LO] != `CPP_JMP_OP |-> ##2 dmem_wr)
    else $error("no write after read");
  a_jump_flush: assert property (phase_4 && !flush_ff &&
    instruction_latch_ff[`CPP_OP_HI:`CPP_OP_LO] == `CPP_JMP_OP |-> ##2 phase_2 && flush_ff)
    else $error("jump left next slot live");
  a_xtal_pin: assert property (osc_drive_active == (osc_mode inside {3'h2, 3'h3, 3'h4}))
    else $error("crystal drive mode wrong");
  a_clock_pin: assert property (osc_input_active == (osc_mode != `CPP_OSC_INTERNAL_RC_MODE))
    else $error("clock input mode wrong");
  a_master_clear_n_hold: assert property (disable iff (rst) master_clear_n_en && !port_in[3] |=>
    phase_1 && flush_ff && program_counter_ff == `CPP_RESET_ADDR)
    else $error("master clear ignored");
  c_write: cover property (dmem_wr);
  c_flush: cover property (flush_ff && phase_2);
  c_master_clear_n: cover property (master_clear_n_en && !port_in[3]);
endmodule
bind cpp_core cpp_core_asserts u_chk (.*);

// ### sim/tb_clock_phase_pipeline_timing.sv
// self-checking bench for the clock phase and pipeline core
`timescale 1ns/100ps
`include "cpp_defs.vh"
module tb_clock_phase_pipeline_timing;
  logic mclk = 1'b0, rst = 1'b1, master_clear_n_en = 1'b1, cycle_clock_out_en = 1'b1;
  logic pm_wr_en = 1'b0, ioc_clr = 1'b0;
  logic [2:0] osc_mode = 3'h0, pullup_sw_en = 3'h3, ioc_en = 3'h0;
  logic [1:0] port_bit2_sel = 2'h0;
  logic [5:0] port_in = 6'h00;
  logic [`CPP_PROG_AW-1:0] pm_wr_addr = 11'h000;
  logic [`CPP_INSN_W-1:0] pm_wr_data = 14'h0000;
  logic [`CPP_PC_W-1:0] pc0;
  wire [`CPP_DATA_W-1:0] dmem_rdata, dmem_wdata_ff;
  wire [`CPP_DADDR_W-1:0] dmem_addr_ff;
  wire [`CPP_PC_W-1:0] program_counter_ff;
  wire [`CPP_INSN_W-1:0] instruction_latch_ff;
  wire [5:0] pin_out, pin_oe_n;
  wire [2:0] pullup_on;
  wire dmem_rd, dmem_wr, phase_1, phase_2, phase_3, phase_4, flush_ff, core_reset, ioc_flag_ff;
  wire osc_drive_active, osc_input_active, timer_ext_clock_in, ext_irq_in;
  int err_total = 0, samples_checked = 0, cyc = 0, rises = 0;
  logic last_clk;
  // oe_n bit4 high so a released cycle clock pin shows the gpio setting
  logic [5:0] port_out = 6'h2a, port_oe_n = 6'h10;
  cpp_core u_dut (.*);
  cpp_dmem_model u_mem (.*);
  initial forever #5 mclk = ~mclk;
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic pw(input logic [10:0] a, input logic [13:0] d);
    @(posedge mclk);
    pm_wr_en <= 1'b1;
    pm_wr_addr <= a;
    pm_wr_data <= d;
  endtask
  // lands on the settled phase_2 of the next instruction slot
  task automatic slot;
    do @(negedge mclk); while (phase_2 !== 1'b1);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop;
    end
    if (dmem_wr === 1'b1)
      chk("wdata", dmem_wdata_ff, 8'(u_mem.mem_ff[dmem_addr_ff] + 8'h01));
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    pw(11'h000, 14'h0011);
    pw(11'h001, 14'h0022);
    pw(11'h002, 14'h2808);
    pw(11'h003, 14'h0033);
    pw(11'h008, 14'h0044);
    pw(11'h009, 14'h2808);
    pw(11'h00a, 14'h0055);
    @(posedge mclk);
    pm_wr_en <= 1'b0;
    @(negedge mclk);
    chk("held_phase", {phase_1, phase_2, phase_3, phase_4}, 4'h8);
    chk("master_clear_n_hold", core_reset, 1'b1);
    chk("rst_pc", program_counter_ff, `CPP_RESET_ADDR);
    chk("rst_latch", instruction_latch_ff, `CPP_NOP_WORD);
    chk("master_clear_n_pullup", pullup_on, 3'h7);
    chk("clk_out_oe", pin_oe_n[4], 1'b0);
    @(posedge mclk);
    port_in[3] <= 1'b1;
    slot;
    chk("bubble", instruction_latch_ff, `CPP_NOP_WORD);
    slot;
    pc0 = program_counter_ff;
    chk("first_word", instruction_latch_ff, 14'h0011);
    slot;
    chk("second_word", instruction_latch_ff, 14'h0022);
    chk("pc_step", program_counter_ff, pc0 + 13'h0001);
    slot;
    chk("jump_word", instruction_latch_ff, 14'h2808);
    slot;
    chk("flush", flush_ff, 1'b1);
    slot;
    chk("jump_target", instruction_latch_ff, 14'h0044);
    chk("pc_after_jump", program_counter_ff, 13'h000a);
    @(posedge mclk);
    master_clear_n_en <= 1'b0;
    port_in[3] <= 1'b0;
    ioc_en <= 3'h1;
    @(negedge mclk);
    chk("no_master_clear_n", core_reset, 1'b0);
    chk("sw_pullup", pullup_on, 3'h3);
    chk("ioc_idle", ioc_flag_ff, 1'b0);
    @(posedge mclk);
    port_in[0] <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("ioc_set", ioc_flag_ff, 1'b1);
    @(posedge mclk);
    ioc_clr <= 1'b1;
    port_in[2] <= 1'b1;
    @(posedge mclk);
    ioc_clr <= 1'b0;
    @(negedge mclk);
    chk("ioc_clr", ioc_flag_ff, 1'b0);
    @(posedge mclk);
    ioc_clr <= 1'b1;
    port_in[0] <= 1'b0;
    @(posedge mclk);
    ioc_clr <= 1'b0;
    @(negedge mclk);
    chk("ioc_set_wins", ioc_flag_ff, 1'b1);
    for (int s = 0; s < 3; s++) begin
      @(posedge mclk);
      port_bit2_sel <= 2'(s);
      @(negedge mclk);
      chk("tmr_clk", timer_ext_clock_in, s == 1);
      chk("ext_irq", ext_irq_in, s == 2);
      chk("p2_oe", pin_oe_n[2], s != 0);
    end
    for (int m = 0; m < 5; m++) begin
      @(posedge mclk);
      osc_mode <= 3'(m);
      @(negedge mclk);
      chk("osc_drive", osc_drive_active, m > 1);
      chk("osc_in", osc_input_active, m != 1);
      chk("p4_oe", pin_oe_n[4], m > 1);
      chk("p5_oe", pin_oe_n[5], m != 1);
      rises = 0;
      repeat (16) begin
        last_clk = pin_out[4];
        @(negedge mclk);
        if (pin_out[4] === 1'b1 && last_clk === 1'b0) rises++;
      end
      chk("cycle_clock_out_rate", 16'(rises), (m < 2) ? 16'h0004 : 16'h0000);
    end
    @(posedge mclk);
    osc_mode <= `CPP_OSC_EXTERNAL_RC_MODE;
    cycle_clock_out_en <= 1'b0;
    @(negedge mclk);
    chk("pin_out", pin_out, 6'h22);
    chk("pin_oe", pin_oe_n, 6'h3c);
    report_and_stop;
  end
endmodule
